// ---- logic/framer_cfg.svh ----
// Constants of the code word framer: timing, frame layout and register map.
`ifndef FRAMER_CFG_SVH
`define FRAMER_CFG_SVH
`define CLK_MHZ 250
`define ELEM_US_ALL 400
`define ELEM_US_HALF 200
`define ELEM_US_QUARTER 100
`define ELEM_CYC_ALL (`ELEM_US_ALL * `CLK_MHZ)
`define ELEM_CYC_HALF (`ELEM_US_HALF * `CLK_MHZ)
`define ELEM_CYC_QUARTER (`ELEM_US_QUARTER * `CLK_MHZ)
`define TX_DELAY_MS 15
`define TX_DELAY_CYC (`TX_DELAY_MS * 1000 * `CLK_MHZ)
`define SHUTOFF_S 25
`define SHUTOFF_CYC (64'(`SHUTOFF_S) * 1000000 * `CLK_MHZ)
`define PREAMBLE_ELEMS 23
`define HEADER_ELEMS 10
`define GUARD_ELEMS 39
`define ELEMS_PER_BIT 3
`define WORD_BITS 66
`define HOP_LSB 0
`define SERIAL_LSB 32
`define BUTTON_LSB 60
`define VLOW_BIT 64
`define REPEAT_BIT 65
`define REG_CTRL 12'h000
`define REG_HOP 12'h004
`define REG_SERIAL 12'h008
`define REG_STATUS 12'h00C
`define REG_COUNT 12'h010
`define CTRL_RESET 32'h0000_0001
`endif

// ---- logic/framer_pkg.sv ----
// Types shared by the code word framer modules.
package framer_pkg;
    typedef enum logic [1:0] {
        RATE_ALL = 2'h0,
        RATE_HALF = 2'h1,
        RATE_QUARTER = 2'h2
    } rate_t;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b00_0001,
        ST_DELAY = 6'b00_0010,
        ST_PREAMBLE = 6'b00_0100,
        ST_HEADER = 6'b00_1000,
        ST_DATA = 6'b01_0000,
        ST_GUARD = 6'b10_0000
    } state_t;
endpackage

// ---- logic/word_if.sv ----
// Handshake carrying one 66-bit code word into the serialiser.
`timescale 1ns/1ns
interface word_if;
    logic valid;
    logic ready;
    logic [65:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// ---- logic/word_buffer.sv ----
// Two-entry buffer holding code words between the assembler and the serialiser.
`timescale 1ns/1ns
module word_buffer (
    input wire logic clk, // Clock.
    input wire logic rstn, // Asynchronous reset, active low.
    word_if.dst in_w, // Words entering.
    word_if.src out_w // Words leaving.
);
    logic [65:0] mem [2];
    logic wr_ptr;
    logic rd_ptr;
    logic [1:0] count;

    // Ready and valid follow the fill level.
    assign in_w.ready = (count != 2'h2);
    assign out_w.valid = (count != 2'h0);
    assign out_w.data = mem[rd_ptr];

    // Write side stores a word on a handshake.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr <= 1'b0;
        end else if (in_w.valid && in_w.ready) begin
            mem[wr_ptr] <= in_w.data;
            wr_ptr <= ~wr_ptr;
        end
    end

    // Read side advances on a handshake.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rd_ptr <= 1'b0;
        end else if (out_w.valid && out_w.ready) begin
            rd_ptr <= ~rd_ptr;
        end
    end

    // Fill level tracks both sides.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= 2'h0;
        end else begin
            count <= count + 2'((in_w.valid && in_w.ready) ? 1 : 0)
                - 2'((out_w.valid && out_w.ready) ? 1 : 0);
        end
    end
endmodule

// ---- logic/pwm_serializer.sv ----
// Serialiser that sends one buffered code word as a PWM frame.
`timescale 1ns/1ns
`include "framer_cfg.svh"
module pwm_serializer (
    input wire logic clk, // Clock.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire framer_pkg::rate_t rate, // Element rate selection.
    word_if.dst in_w, // Word to send.
    output logic pwm_out, // PWM data level.
    output logic busy, // Frame in progress.
    output logic frame_done // One-cycle pulse at frame end.
);
    import framer_pkg::*;
    state_t state;
    logic [17:0] elem_cnt;
    logic [6:0] phase;
    logic [6:0] bit_idx;
    logic [1:0] sub;
    logic [65:0] word;
    logic elem_tick;

    // Cycles in one element for the selected rate.
    function automatic logic [17:0] elem_len(input rate_t r);
        case (r)
            RATE_HALF: elem_len = 18'(`ELEM_CYC_HALF);
            RATE_QUARTER: elem_len = 18'(`ELEM_CYC_QUARTER);
            default: elem_len = 18'(`ELEM_CYC_ALL);
        endcase
    endfunction

    assign elem_tick = (elem_cnt == elem_len(rate) - 18'h0_0001);
    assign in_w.ready = (state == ST_IDLE);

    // Element timer runs while a frame is on the air.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            elem_cnt <= 18'h0_0000;
        end else if (state == ST_IDLE || elem_tick) begin
            elem_cnt <= 18'h0_0000;
        end else begin
            elem_cnt <= elem_cnt + 18'h0_0001;
        end
    end

    // Frame sequence: preamble, header, data, guard. [RL1] [RL14]
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state <= ST_IDLE;
            phase <= 7'h00;
            bit_idx <= 7'h00;
            sub <= 2'h0;
            word <= '0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (in_w.valid) begin
                        word <= in_w.data;
                        phase <= 7'h00;
                        state <= ST_PREAMBLE;
                    end
                end
                ST_PREAMBLE: begin
                    if (elem_tick) begin
                        phase <= phase + 7'h01;
                        if (phase == 7'(`PREAMBLE_ELEMS - 1)) begin // [RL14]
                            phase <= 7'h00;
                            state <= ST_HEADER;
                        end
                    end
                end
                ST_HEADER: begin
                    if (elem_tick) begin
                        phase <= phase + 7'h01;
                        if (phase == 7'(`HEADER_ELEMS - 1)) begin // [RL14]
                            bit_idx <= 7'h00;
                            sub <= 2'h0;
                            state <= ST_DATA;
                        end
                    end
                end
                ST_DATA: begin
                    if (elem_tick) begin
                        sub <= sub + 2'h1;
                        if (sub == 2'(`ELEMS_PER_BIT - 1)) begin // [RL5]
                            sub <= 2'h0;
                            bit_idx <= bit_idx + 7'h01;
                            if (bit_idx == 7'(`WORD_BITS - 1)) begin
                                phase <= 7'h00;
                                state <= ST_GUARD;
                            end
                        end
                    end
                end
                ST_GUARD: begin
                    if (elem_tick) begin
                        phase <= phase + 7'h01;
                        if (phase == 7'(`GUARD_ELEMS - 1)) begin // [RL14]
                            frame_done <= 1'b1;
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Line level: preamble alternates, bits sent LSB first. [RL13] [RL2] [RL3]
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwm_out <= 1'b0;
            busy <= 1'b0;
        end else begin
            busy <= (state != ST_IDLE);
            case (state)
                ST_PREAMBLE: pwm_out <= ~phase[0];
                ST_DATA: pwm_out <= (sub == 2'h0) || (sub == 2'h1 && !word[bit_idx]); // [RL13]
                default: pwm_out <= 1'b0;
            endcase
        end
    end
endmodule

// ---- logic/code_word_pwm_framer.sv ----
// Top of the code word framer: APB registers, button logic and word assembly.
// How it works
// [RL1] Frame is preamble, header, hopping, fixed, guard.
// [RL2] Hopping code bits 0-31, LSB first.
// [RL3] Serial number bits 32-59, LSB first.
// [RL4] Buttons 3,0,1,2 then low battery, repeat.
// [RL5] Hopping code takes ninety-six elements.
// [RL6] Element 400, 200 or 100 microseconds.
// [RL7] Transmit starts 10 to 25 ms after press.
// [RL8] Extra button in delay joins the combination.
// [RL9] Auto-shutoff stops held transmission after timeout.
// [RL10] Repeat flag zero first, one afterwards.
// [RL11] Low battery flag set when supply low.
// [RL12] Auto-shutoff enabled by its configuration bit.
// [RL13] One: high one, low two; zero: high two, low one.
// [RL14] Preamble 23, header 10, guard 39 elements.
`timescale 1ns/1ns
`include "framer_cfg.svh"
module code_word_pwm_framer #(
    parameter logic [63:0] TX_DELAY = 64'(`TX_DELAY_CYC), // Transmit delay in cycles.
    parameter logic [63:0] SHUTOFF = `SHUTOFF_CYC // Auto-shutoff timeout in cycles.
) (
    input wire logic clk, // Clock, 250 MHz.
    input wire logic rstn, // Asynchronous reset, active low.
    input wire logic psel, // APB select.
    input wire logic penable, // APB enable.
    input wire logic pwrite, // APB write.
    input wire logic [11:0] paddr, // APB byte address.
    input wire logic [31:0] pwdata, // APB write data.
    output logic [31:0] prdata, // APB read data.
    output logic pready, // APB ready.
    output logic pslverr, // APB error.
    input wire logic button_in_0, // Button input 0.
    input wire logic button_in_1, // Button input 1.
    input wire logic button_in_2, // Button input 2.
    input wire logic button_in_3, // Button input 3.
    input wire logic supply_low, // Supply below trip point.
    output logic pwm_data, // PWM data to the RF stage.
    output logic transmitting // Frame on the air.
);
    import framer_pkg::*;
    word_if asm_w();
    word_if ser_w();
    state_t tx_state;
    logic [31:0] ctrl;
    logic [31:0] hop_code;
    logic [27:0] serial;
    logic [31:0] word_count;
    logic [63:0] delay_cnt;
    logic [63:0] hold_cnt;
    logic [3:0] buttons;
    logic [3:0] latched;
    logic repeat_flag;
    logic shut;
    logic pwm_raw;
    logic busy_raw;
    logic frame_done;
    logic any_button;
    logic apb_go;
    logic addr_ok;
    rate_t rate;

    assign buttons = {button_in_3, button_in_2, button_in_1, button_in_0};
    assign any_button = |buttons;
    assign rate = rate_t'(ctrl[2:1]); // [RL6]
    assign apb_go = psel && penable;

    // Decodes whether an address belongs to the register map.
    function automatic logic addr_hit(input logic [11:0] a);
        addr_hit = (a == `REG_CTRL) || (a == `REG_HOP) || (a == `REG_SERIAL)
            || (a == `REG_STATUS) || (a == `REG_COUNT);
    endfunction

    assign addr_ok = addr_hit(paddr);

    // APB answers every access in its first access cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !addr_ok;
        end
    end

    // Register writes land on the access edge.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ctrl <= `CTRL_RESET;
            hop_code <= 32'h0000_0000;
            serial <= 28'h000_0000;
        end else if (apb_go && pready && pwrite) begin
            case (paddr)
                `REG_CTRL: ctrl <= {29'h0000_0000, pwdata[2:0]};
                `REG_HOP: hop_code <= pwdata;
                `REG_SERIAL: serial <= pwdata[27:0];
                default: ;
            endcase
        end
    end

    // Read data is prepared in the setup cycle.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable) begin
            case (paddr)
                `REG_CTRL: prdata <= ctrl;
                `REG_HOP: prdata <= hop_code;
                `REG_SERIAL: prdata <= {4'h0, serial};
                `REG_STATUS: prdata <= {24'h00_0000, tx_state == ST_IDLE ? 1'b0 : 1'b1,
                    shut, repeat_flag, latched, busy_raw};
                `REG_COUNT: prdata <= word_count;
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // Press handling: delay, combination capture, repeats, auto-shutoff.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tx_state <= ST_IDLE;
            delay_cnt <= 64'h0;
            latched <= 4'h0;
            repeat_flag <= 1'b0;
            asm_w.valid <= 1'b0;
            asm_w.data <= '0;
        end else begin
            if (asm_w.valid && asm_w.ready) begin
                asm_w.valid <= 1'b0;
                repeat_flag <= 1'b1; // [RL10]
            end
            case (tx_state)
                ST_IDLE: begin
                    repeat_flag <= 1'b0; // [RL10]
                    if (any_button && !shut) begin
                        latched <= buttons;
                        delay_cnt <= 64'h0;
                        tx_state <= ST_DELAY;
                    end
                end
                ST_DELAY: begin
                    latched <= latched | buttons; // [RL8]
                    delay_cnt <= delay_cnt + 64'h1;
                    if (delay_cnt == TX_DELAY - 64'h1) begin // [RL7]
                        tx_state <= ST_DATA;
                    end
                end
                ST_DATA: begin
                    // A press released during the delay still sends its first word. [RL7]
                    if ((!any_button && repeat_flag) || shut) begin // [RL9]
                        if (!asm_w.valid && !busy_raw) begin
                            tx_state <= ST_IDLE;
                        end
                    end else if (!asm_w.valid && !busy_raw) begin
                        latched <= latched | buttons; // [RL8]
                        asm_w.valid <= 1'b1;
                        // Word layout, LSB first on the line. [RL2] [RL3] [RL4] [RL11]
                        asm_w.data <= {repeat_flag, supply_low, latched[2], latched[1],
                            latched[0], latched[3], serial, hop_code};
                    end
                end
                default: tx_state <= ST_IDLE;
            endcase
        end
    end

    // Hold timer for auto-shutoff while buttons stay pressed. [RL9] [RL12]
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hold_cnt <= 64'h0;
            shut <= 1'b0;
        end else if (!any_button) begin
            hold_cnt <= 64'h0;
            shut <= 1'b0;
        end else if (ctrl[0] && hold_cnt == SHUTOFF - 64'h1) begin // [RL12]
            shut <= 1'b1;
        end else begin
            hold_cnt <= hold_cnt + 64'h1;
        end
    end

    // Counts completed frames for software.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            word_count <= 32'h0000_0000;
        end else if (frame_done) begin
            word_count <= word_count + 32'h0000_0001;
        end
    end

    // Line outputs registered once more at the top.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pwm_data <= 1'b0;
            transmitting <= 1'b0;
        end else begin
            pwm_data <= pwm_raw;
            transmitting <= busy_raw;
        end
    end

    word_buffer u_buf (
        .clk(clk),
        .rstn(rstn),
        .in_w(asm_w),
        .out_w(ser_w)
    );

    pwm_serializer u_ser (
        .clk(clk),
        .rstn(rstn),
        .rate(rate),
        .in_w(ser_w),
        .pwm_out(pwm_raw),
        .busy(busy_raw),
        .frame_done(frame_done)
    );
endmodule

// ---- bench/framer_properties.sv ----
// Checker of the framer's bus answers and PWM line timing.
`timescale 1ns/1ns
module framer_properties (
    input wire logic clk, // Clock.
    input wire logic rstn, // Reset, active low.
    input wire logic psel, // Select.
    input wire logic penable, // Enable.
    input wire logic [11:0] paddr, // Address.
    input wire logic [31:0] prdata, // Read data.
    input wire logic pready, // Ready.
    input wire logic pslverr, // Error.
    input wire logic button_in_0, // Button 0.
    input wire logic button_in_1, // Button 1.
    input wire logic button_in_2, // Button 2.
    input wire logic button_in_3, // Button 3.
    input wire logic pwm_data, // PWM line.
    input wire logic transmitting // Frame on the air.
);
    // Any button held.
    wire logic any_btn = button_in_0 | button_in_1 | button_in_2 | button_in_3;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_press;
        $rose(any_btn) && !transmitting && !pwm_data;
    endsequence
    property p_pready;
        s_setup |=> pready;
    endproperty
    a_pready: assert property (p_pready) else $error("no ready after setup");
    property p_pready_once;
        pready |=> !pready;
    endproperty
    a_pready_once: assert property (p_pready_once) else $error("ready held too long");
    property p_unmapped;
        pready && paddr > 12'h010 |-> pslverr;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access accepted");
    property p_err_ready;
        pslverr |-> pready;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("error without ready");
    property p_err_data;
        pready && pslverr |-> prdata == 32'h0000_0000;
    endproperty
    a_err_data: assert property (p_err_data) else $error("error read returned data");
    property p_hold;
        !(psel && !penable) |=> $stable(prdata);
    endproperty
    a_hold: assert property (p_hold) else $error("read data changed");
    property p_no_early;
        s_press |-> !pwm_data [*8];
    endproperty
    a_no_early: assert property (p_no_early) else $error("frame began too soon");
    property p_high_min;
        $rose(pwm_data) |-> pwm_data [*8];
    endproperty
    a_high_min: assert property (p_high_min) else $error("high level too short");
    property p_low_min;
        $fell(pwm_data) |-> !pwm_data [*8];
    endproperty
    a_low_min: assert property (p_low_min) else $error("low level too short");
    property p_tx_flag;
        $rose(pwm_data) |-> ##[0:4] transmitting;
    endproperty
    a_tx_flag: assert property (p_tx_flag) else $error("frame flag missing");
endmodule

bind code_word_pwm_framer framer_properties u_props (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .button_in_0(button_in_0),
    .button_in_1(button_in_1), .button_in_2(button_in_2), .button_in_3(button_in_3),
    .pwm_data(pwm_data), .transmitting(transmitting)
);

// ---- bench/rf_receiver.sv ----
// Model of the RF stage that times the first pulses of a frame.
`timescale 1ns/1ns
module rf_receiver (
    input wire logic clk, // Clock.
    input wire logic rstn, // Reset, active low.
    input wire logic arm, // Starts a measurement.
    input wire logic pwm_line, // PWM data from the framer.
    output logic [31:0] gap, // Cycles from arm to first rise.
    output logic [31:0] hi_len, // Cycles of first high.
    output logic [31:0] lo_len, // Cycles of first low.
    output logic rose_seen, // First rise found.
    output logic done // High and low measured.
);
    logic [1:0] stage;
    // Counts the wait, then the first high and low levels.
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stage <= 2'd3;
            gap <= 32'h0000_0000;
            hi_len <= 32'h0000_0000;
            lo_len <= 32'h0000_0000;
            rose_seen <= 1'b0;
            done <= 1'b0;
        end else if (arm) begin
            stage <= 2'd0;
            gap <= 32'h0000_0000;
            hi_len <= 32'h0000_0000;
            lo_len <= 32'h0000_0000;
            rose_seen <= 1'b0;
            done <= 1'b0;
        end else begin
            case (stage)
                2'd0: if (pwm_line) begin
                    stage <= 2'd1;
                    rose_seen <= 1'b1;
                    hi_len <= 32'h0000_0001;
                end else gap <= gap + 1;
                2'd1: if (!pwm_line) begin
                    stage <= 2'd2;
                    lo_len <= 32'h0000_0001;
                end else hi_len <= hi_len + 1;
                2'd2: if (pwm_line) begin
                    stage <= 2'd3;
                    done <= 1'b1;
                end else lo_len <= lo_len + 1;
                default: stage <= 2'd3;
            endcase
        end
    end
endmodule

// ---- bench/tb_code_word_pwm_framer.sv ----
// Self-checking bench of the code word framer.
`timescale 1ns/1ns
`include "framer_cfg.svh"
module tb_code_word_pwm_framer;
    localparam logic [63:0] T_DELAY = 64'h0000_0000_0000_00C8; // 200 cycles.
    localparam logic [63:0] T_OFF = 64'h0000_0000_0000_4E20; // 20000 cycles.
    localparam int LIMIT = 90000;
    logic clk, rstn, psel, penable, pwrite, pready, pslverr, e;
    logic supply_low, pwm_data, transmitting, arm, rose_seen, done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, gap, hi_len, lo_len;
    logic [3:0] btn;
    int miscompares, tests_run, cycles, n;

    code_word_pwm_framer #(.TX_DELAY(T_DELAY), .SHUTOFF(T_OFF)) uut (
        .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .button_in_0(btn[0]), .button_in_1(btn[1]),
        .button_in_2(btn[2]), .button_in_3(btn[3]), .supply_low(supply_low),
        .pwm_data(pwm_data), .transmitting(transmitting));
    rf_receiver rx (.clk(clk), .rstn(rstn), .arm(arm), .pwm_line(pwm_data), .gap(gap),
        .hi_len(hi_len), .lo_len(lo_len), .rose_seen(rose_seen), .done(done));

    // Clock at 250 MHz.
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Ends a run that hangs.
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            miscompares++;
            wrap_up();
        end
    end

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // One APB transfer; the request stands until ready is sampled high.
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 16) miscompares++;
    endtask

    task do_reset();
        rstn <= 1'b0;
        btn <= 4'h0;
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
    endtask

    // Presses buttons and starts the receiver's timing at the same edge.
    task press(input logic [3:0] b);
        @(posedge clk);
        btn <= b;
        arm <= 1'b1;
        @(posedge clk);
        arm <= 1'b0;
    endtask

    task check_start();
        n = 0;
        while (rose_seen !== 1'b1 && n < 1000) begin
            @(posedge clk);
            n++;
        end
        check("start", 32'(gap >= 32'(T_DELAY) && gap <= 32'(T_DELAY) + 16), 32'h1);
    endtask

    task t_regs();
        apb(1'b0, `REG_CTRL, 32'h0000_0000);
        check("ctrl", q, 32'h0000_0001);
        apb(1'b1, `REG_CTRL, 32'h0000_0003);
        apb(1'b0, `REG_CTRL, 32'h0000_0000);
        check("ctrl rate", q, 32'h0000_0003);
        apb(1'b1, `REG_HOP, 32'h1234_5678);
        apb(1'b0, `REG_HOP, 32'h0000_0000);
        check("hop", q, 32'h1234_5678);
        apb(1'b1, `REG_SERIAL, 32'h0ABC_DEF1);
        apb(1'b0, `REG_SERIAL, 32'h0000_0000);
        check("serial", q, 32'h0ABC_DEF1);
        apb(1'b1, `REG_STATUS, 32'hFFFF_FFFF);
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        check("status", q, 32'h0000_0000);
        apb(1'b0, `REG_COUNT, 32'h0000_0000);
        check("count", q, 32'h0000_0000);
        apb(1'b1, 12'h100, 32'hFFFF_FFFF);
        check("wr err", 32'(e), 32'h1);
        apb(1'b0, 12'h100, 32'h0000_0000);
        check("rd err", 32'(e), 32'h1);
        check("rd err data", q, 32'h0000_0000);
    endtask

    // Held button with auto-shutoff on: timeout must be flagged.
    task t_shutoff();
        press(4'b0010);
        check_start();
        repeat (int'(T_OFF) + 500) @(posedge clk);
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        check("shutoff", q & 32'h0000_0040, 32'h0000_0040);
        check("repeat", q & 32'h0000_0020, 32'h0000_0020);
        check("latched", q & 32'h0000_001E, 32'h0000_0004);
        do_reset();
    endtask

    // Quarter rate, shutoff off: time the first preamble elements.
    task t_preamble();
        apb(1'b1, `REG_CTRL, 32'h0000_0004);
        supply_low <= 1'b1;
        press(4'b1000);
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        check("first word", q & 32'h0000_00A0, 32'h0000_0080);
        check_start();
        n = 0;
        while (done !== 1'b1 && n < 60000) begin
            @(posedge clk);
            n++;
        end
        check("high elem", hi_len, 32'(`ELEM_CYC_QUARTER));
        check("low elem", lo_len, 32'(`ELEM_CYC_QUARTER));
        check("on air", 32'(transmitting), 32'h1);
        apb(1'b0, `REG_STATUS, 32'h0000_0000);
        check("busy no off", q & 32'h0000_0041, 32'h0000_0001);
    endtask

    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        btn = 4'h0;
        supply_low = 1'b0;
        arm = 1'b0;
        miscompares = 0;
        tests_run = 0;
        cycles = 0;
        do_reset();
        t_regs();
        t_shutoff();
        t_preamble();
        wrap_up();
    end
endmodule
